// >>> common/sptx_pkg.sv
package sptx_pkg;
    localparam int unsigned AXI_AW       = 12;
    localparam int unsigned SAMPLE_W     = 24;
    localparam int unsigned ENTRY_W      = 27;
    localparam int unsigned FIFO_DEPTH   = 8;
    localparam int unsigned CNT_W        = 4;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_VALIDITY = 8'h06;
    localparam logic [7:0]  IDX_SOURCE   = 8'h15;
    localparam logic [7:0]  IDX_POWER    = 8'h1e;
    localparam logic [7:0]  IDX_CS_LO    = 8'h20;
    localparam logic [7:0]  IDX_CS_HI    = 8'h21;
    localparam logic [7:0]  IDX_CS_CHN   = 8'h22;
    localparam logic [7:0]  IDX_STATUS   = 8'h23;
    localparam int unsigned BIT_VAL_SF0  = 5;
    localparam int unsigned BIT_VAL_SF1  = 6;
    localparam int unsigned BIT_VAL_OVR  = 7;
    localparam int unsigned BIT_TX_DATA_SOURCE_SEL    = 6;
    localparam int unsigned BIT_STATSRC  = 7;
    localparam int unsigned BIT_TXPD     = 2;
    localparam logic [7:0]  RST_VALIDITY = 8'h00;
    localparam logic [7:0]  RST_SOURCE   = 8'h71;
    localparam logic [7:0]  RST_POWER    = 8'h04;
    localparam logic [31:0] RST_CS_LO    = 32'h0000_0000;
    localparam logic [7:0]  RST_CS_HI    = 8'h00;
    localparam logic [7:0]  RST_CS_CHN   = 8'h00;
    localparam logic [7:0]  FRAME_LAST   = 8'hbf;
    localparam logic [7:0]  CS_DEFINED   = 8'h28;
    localparam logic [7:0]  PRE_B        = 8'he8;
    localparam logic [7:0]  PRE_M        = 8'he2;
    localparam logic [7:0]  PRE_W        = 8'he4;
    localparam logic [5:0]  H_FIRST      = 6'h00;
    localparam logic [5:0]  H_PRE_END    = 6'h08;
    localparam logic [5:0]  H_LAST       = 6'h3f;
    localparam logic [3:0]  AUX_ZERO     = 4'h0;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [15:0] HALF_CELL_DEF = 16'h0029;
    typedef enum logic [1:0] {
        TX_OFF = 2'b01,
        TX_RUN = 2'b10
    } sptx_state_t;
endpackage : sptx_pkg

// >>> logic/sptx_top.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
module sptx_fifo #(
    parameter int unsigned WIDTH = 27,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       in_valid_in,
    output logic                            in_ready_out,
    input  wire logic [WIDTH-1:0]           in_data_in,
    output logic                            out_valid_out,
    input  wire logic                       out_ready_in,
    output logic [WIDTH-1:0]                out_data_out,
    output logic [$clog2(DEPTH+1)-1:0]      count_out
);
    localparam int unsigned CW = $clog2(DEPTH+1);
    localparam int unsigned PW = $clog2(DEPTH);
    // depth must be a power of two: pointers wrap naturally
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [CW-1:0]    count_q;
    wire              push = in_valid_in & in_ready_out;
    wire              pop  = out_valid_out & out_ready_in;
    assign in_ready_out  = count_q < CW'(DEPTH);
    assign out_valid_out = count_q != '0;
    assign out_data_out  = mem_q[rd_q];
    assign count_out     = count_q;
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            wr_q    <= wr_q + PW'(push);
            rd_q    <= rd_q + PW'(pop);
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
    AST_FIFO_NO_OVERRUN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (count_q == CW'(DEPTH)) |-> !in_ready_out)
        else $error("fifo offers room while full");
endmodule : sptx_fifo

module sptx_top #(
    parameter logic [15:0] HALF_CELL_CYCLES = sptx_pkg::HALF_CELL_DEF
) (
    input  wire logic                          SYS_CLK_IN,
    input  wire logic                          RST_N_IN,
    input  wire logic [sptx_pkg::AXI_AW-1:0]   S_AXI_AWADDR_IN,
    input  wire logic                          S_AXI_AWVALID_IN,
    output logic                               S_AXI_AWREADY_OUT,
    input  wire logic [31:0]                   S_AXI_WDATA_IN,
    input  wire logic [3:0]                    S_AXI_WSTRB_IN,
    input  wire logic                          S_AXI_WVALID_IN,
    output logic                               S_AXI_WREADY_OUT,
    output logic [1:0]                         S_AXI_BRESP_OUT,
    output logic                               S_AXI_BVALID_OUT,
    input  wire logic                          S_AXI_BREADY_IN,
    input  wire logic [sptx_pkg::AXI_AW-1:0]   S_AXI_ARADDR_IN,
    input  wire logic                          S_AXI_ARVALID_IN,
    output logic                               S_AXI_ARREADY_OUT,
    output logic [31:0]                        S_AXI_RDATA_OUT,
    output logic [1:0]                         S_AXI_RRESP_OUT,
    output logic                               S_AXI_RVALID_OUT,
    input  wire logic                          S_AXI_RREADY_IN,
    input  wire logic                          RX_VALID_IN,
    input  wire logic [sptx_pkg::SAMPLE_W-1:0] RX_SAMPLE_IN,
    input  wire logic                          RX_VALIDITY_IN,
    input  wire logic                          RX_USER_IN,
    input  wire logic                          RX_STATUS_IN,
    output logic                               RX_READY_OUT,
    input  wire logic                          AIF_VALID_IN,
    input  wire logic [sptx_pkg::SAMPLE_W-1:0] AIF_SAMPLE_IN,
    output logic                               AIF_READY_OUT,
    input  wire logic                          HW_MODE_IN,
    input  wire logic                          STRAP_PIN_TX_SOURCE_IN,
    input  wire logic                          STRAP_BCLK_IN,
    input  wire logic [1:0]                    RX_FREQ_BAND_IN,
    output logic                               RX_ENABLE_OUT,
    output logic                               PLL_AUTO_OUT,
    output logic [1:0]                         PLL_FREQ_BAND_OUT,
    output logic                               AUDIO_IF_MASTER_SEL_OUT,
    output logic                               TX_OUT_PIN_OUT
);
    import sptx_pkg::*;

    logic                 awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic                 aw_held_q, w_held_q;
    logic [AXI_AW-1:0]    aw_addr_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic [1:0]           bresp_q, rresp_q;
    logic [31:0]          rdata_q;
    logic [7:0]           val_q, src_q, pwr_q, cs_hi_q, chn_q;
    logic [31:0]          cs_lo_q;
    logic                 cap_done_q, hw_q, strap_src_q, strap_ms_q;
    logic                 rx_en_q, pll_auto_q, audio_if_master_sel_q;
    logic [1:0]           band_q;
    sptx_state_t          state_q;
    logic [15:0]          div_q;
    logic [5:0]           h_q;
    logic                 sf_q, pol_q, out_q;
    logic [7:0]           frame_q;
    logic [31:0]          word_q;
    logic                 rx_rdy_q, aif_rdy_q;

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    function automatic logic [8:0] reg_index(input logic [AXI_AW-1:0] addr);
        // bit 8 flags an address outside the register window
        reg_index = {addr[AXI_AW-1:10] != '0, addr[9:2]};
    endfunction : reg_index

    function automatic logic [31:0] read_mux(input logic [8:0] idx, input logic [31:0] stat);
        read_mux = 32'h0000_0000;
        case (idx)
            {1'b0, IDX_VALIDITY}: read_mux = {24'h00_0000, val_q};
            {1'b0, IDX_SOURCE}:   read_mux = {24'h00_0000, src_q};
            {1'b0, IDX_POWER}:    read_mux = {24'h00_0000, pwr_q};
            {1'b0, IDX_CS_LO}:    read_mux = cs_lo_q;
            {1'b0, IDX_CS_HI}:    read_mux = {24'h00_0000, cs_hi_q};
            {1'b0, IDX_CS_CHN}:   read_mux = {24'h00_0000, chn_q};
            {1'b0, IDX_STATUS}:   read_mux = stat;
            default:              read_mux = 32'h0000_0000;
        endcase
    endfunction : read_mux

    function automatic logic idx_mapped(input logic [8:0] idx);
        idx_mapped = (idx == {1'b0, IDX_VALIDITY}) || (idx == {1'b0, IDX_SOURCE}) ||
                     (idx == {1'b0, IDX_POWER}) || (idx == {1'b0, IDX_CS_LO}) ||
                     (idx == {1'b0, IDX_CS_HI}) || (idx == {1'b0, IDX_CS_CHN}) ||
                     (idx == {1'b0, IDX_STATUS});
    endfunction : idx_mapped

    // register bus
    wire       aw_take  = S_AXI_AWVALID_IN & awready_q;
    wire       w_take   = S_AXI_WVALID_IN & wready_q;
    wire       wr_fire  = aw_held_q & w_held_q & !bvalid_q;
    wire [8:0] w_idx    = reg_index(aw_addr_q);
    wire       w_ok     = idx_mapped(w_idx);
    wire       w_byte0  = wr_fire & w_strb_q[0];
    wire       ar_take  = S_AXI_ARVALID_IN & arready_q;
    wire [8:0] r_idx    = reg_index(S_AXI_ARADDR_IN);
    wire       fifo_empty;
    wire [31:0] stat_word = {16'h0000, frame_q, 3'h0, fifo_empty, audio_if_master_sel_q,
                             strap_src_q, hw_q, state_q == TX_RUN};

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awready_q <= 1'b0;
                aw_addr_q <= S_AXI_AWADDR_IN;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wready_q <= 1'b0;
                w_data_q <= S_AXI_WDATA_IN;
                w_strb_q <= S_AXI_WSTRB_IN;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= w_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && S_AXI_BREADY_IN) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= read_mux(r_idx, stat_word);
            rresp_q   <= idx_mapped(r_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY_IN) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // configuration registers
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            val_q   <= RST_VALIDITY;
            src_q   <= RST_SOURCE;
            pwr_q   <= RST_POWER;
            cs_lo_q <= RST_CS_LO;
            cs_hi_q <= RST_CS_HI;
            chn_q   <= RST_CS_CHN;
        end else begin
            if (w_byte0 && w_idx == {1'b0, IDX_VALIDITY}) val_q <= w_data_q[7:0];
            if (w_byte0 && w_idx == {1'b0, IDX_SOURCE})   src_q <= w_data_q[7:0];
            if (w_byte0 && w_idx == {1'b0, IDX_POWER})    pwr_q <= w_data_q[7:0];
            if (w_byte0 && w_idx == {1'b0, IDX_CS_HI})    cs_hi_q <= w_data_q[7:0];
            if (w_byte0 && w_idx == {1'b0, IDX_CS_CHN})   chn_q <= w_data_q[7:0];
            if (wr_fire && w_idx == {1'b0, IDX_CS_LO}) begin
                for (int i = 0; i < 4; i++) begin
                    if (w_strb_q[i]) cs_lo_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
                end
            end
        end
    end

    // straps are caught on the first edge after release, never by the reset itself
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cap_done_q  <= 1'b0;
            hw_q        <= 1'b0;
            strap_src_q <= 1'b1;
            strap_ms_q  <= 1'b0;
        end else if (!cap_done_q) begin
            cap_done_q  <= 1'b1;
            hw_q        <= HW_MODE_IN;
            strap_src_q <= STRAP_PIN_TX_SOURCE_IN;
            strap_ms_q  <= STRAP_BCLK_IN;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rx_en_q    <= 1'b0;
            pll_auto_q <= 1'b0;
            audio_if_master_sel_q   <= 1'b0;
            band_q     <= 2'h0;
        end else begin
            rx_en_q    <= hw_q;
            pll_auto_q <= hw_q;
            audio_if_master_sel_q   <= hw_q & strap_ms_q;
            if (hw_q) band_q <= RX_FREQ_BAND_IN;
        end
    end

    // data path selection
    wire from_rx   = hw_q ? !strap_src_q : !src_q[BIT_TX_DATA_SOURCE_SEL];
    wire rx_status = from_rx & !src_q[BIT_STATSRC];
    wire tx_pd     = pwr_q[BIT_TXPD];
    wire tick      = (state_q == TX_RUN) && (div_q == HALF_CELL_CYCLES - 16'h0001);
    wire load      = tick && (h_q == H_FIRST);
    wire frame_end = tick && (h_q == H_LAST);
    wire push      = from_rx ? (RX_VALID_IN & rx_rdy_q) : (AIF_VALID_IN & aif_rdy_q);
    wire [ENTRY_W-1:0] push_data = from_rx ?
        {RX_STATUS_IN, RX_USER_IN, RX_VALIDITY_IN, RX_SAMPLE_IN} :
        {3'h0, AIF_SAMPLE_IN};
    wire               fifo_in_ready;
    wire               fifo_valid;
    wire [ENTRY_W-1:0] fifo_data;
    wire [CNT_W-1:0]   fifo_cnt;
    wire               pop = load & fifo_valid;
    wire [CNT_W-1:0]   cnt_next = fifo_cnt + CNT_W'(push) - CNT_W'(pop);
    wire               room_next = cnt_next < CNT_W'(FIFO_DEPTH);
    assign fifo_empty = !fifo_valid;

    sptx_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (SYS_CLK_IN),
        .rst_n_in      (RST_N_IN),
        .in_valid_in   (push & fifo_in_ready),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (push_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (load),
        .out_data_out  (fifo_data),
        .count_out     (fifo_cnt)
    );

    // ready is registered from the lookahead count, so a granted beat always fits
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rx_rdy_q  <= 1'b0;
            aif_rdy_q <= 1'b0;
        end else begin
            rx_rdy_q  <= from_rx & room_next;
            aif_rdy_q <= !from_rx & room_next;
        end
    end

    // subframe word: aux nibble, sample, validity, user, status, parity
    wire [ENTRY_W-1:0] ent  = fifo_valid ? fifo_data : '0;
    wire [39:0] cs_vec0 = {cs_hi_q, cs_lo_q[31:30], src_q[5:0], chn_q[3:0], cs_lo_q[19:0]};
    wire [39:0] cs_vec1 = {cs_hi_q, cs_lo_q[31:30], src_q[5:0], chn_q[7:4], cs_lo_q[19:0]};
    wire [39:0] cs_vec  = sf_q ? cs_vec1 : cs_vec0;
    wire cs_reg_bit = (frame_q < CS_DEFINED) ? cs_vec[frame_q[5:0]] : 1'b0;
    wire bit_c = rx_status ? ent[SAMPLE_W+2] : cs_reg_bit;
    wire bit_u = rx_status & ent[SAMPLE_W+1];
    wire bit_v = val_q[BIT_VAL_OVR] ?
        (sf_q ? val_q[BIT_VAL_SF1] : val_q[BIT_VAL_SF0]) :
        (from_rx & ent[SAMPLE_W]);
    wire [30:0] body   = {bit_c, bit_u, bit_v, ent[SAMPLE_W-1:0], AUX_ZERO};
    wire [31:0] word_d = {^body, body};
    wire [7:0]  pre_pat = sf_q ? PRE_W : ((frame_q == 8'h00) ? PRE_B : PRE_M);
    wire        pre_lvl = pre_pat[3'h7 - h_q[2:0]] ^ pol_q;
    wire        cell_lvl = (!h_q[0] || word_q[h_q[5:1]]) ? !out_q : out_q;
    wire        out_d = (h_q == H_FIRST) ? !out_q : ((h_q < H_PRE_END) ? pre_lvl : cell_lvl);

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q <= TX_OFF;
        end else begin
            case (state_q)
                TX_OFF:  if (!tx_pd) state_q <= TX_RUN;
                TX_RUN:  if (tx_pd) state_q <= TX_OFF;
                default: state_q <= TX_OFF;
            endcase
        end
    end

    // biphase-mark serializer, two half cells per time slot
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            div_q   <= 16'h0000;
            h_q     <= H_FIRST;
            sf_q    <= 1'b0;
            frame_q <= 8'h00;
            pol_q   <= 1'b0;
            out_q   <= 1'b0;
            word_q  <= 32'h0000_0000;
        end else if (state_q != TX_RUN) begin
            div_q   <= 16'h0000;
            h_q     <= H_FIRST;
            sf_q    <= 1'b0;
            frame_q <= 8'h00;
            out_q   <= 1'b0;
        end else begin
            div_q <= tick ? 16'h0000 : div_q + 16'h0001;
            if (tick) begin
                h_q   <= h_q + 6'h01;
                out_q <= out_d;
            end
            if (load) begin
                pol_q  <= out_q;
                word_q <= word_d;
            end
            if (frame_end) begin
                sf_q <= !sf_q;
                if (sf_q) frame_q <= (frame_q == FRAME_LAST) ? 8'h00 : frame_q + 8'h01;
            end
        end
    end

    assign S_AXI_AWREADY_OUT       = awready_q;
    assign S_AXI_WREADY_OUT        = wready_q;
    assign S_AXI_BRESP_OUT         = bresp_q;
    assign S_AXI_BVALID_OUT        = bvalid_q;
    assign S_AXI_ARREADY_OUT       = arready_q;
    assign S_AXI_RDATA_OUT         = rdata_q;
    assign S_AXI_RRESP_OUT         = rresp_q;
    assign S_AXI_RVALID_OUT        = rvalid_q;
    assign RX_READY_OUT            = rx_rdy_q;
    assign AIF_READY_OUT           = aif_rdy_q;
    assign RX_ENABLE_OUT           = rx_en_q;
    assign PLL_AUTO_OUT            = pll_auto_q;
    assign PLL_FREQ_BAND_OUT       = band_q;
    assign AUDIO_IF_MASTER_SEL_OUT = audio_if_master_sel_q;
    assign TX_OUT_PIN_OUT          = out_q;

    sequence s_load;
        load;
    endsequence
    sequence s_preamble_edge;
        tick && (h_q == H_FIRST) ##1 (out_q != $past(out_q));
    endsequence

    AST_PD_SILENT: assert property (tx_pd ##1 tx_pd |-> ##1 !out_q)
        else $error("line not idle while powered down");
    AST_PREAMBLE_TOGGLE: assert property (s_load |-> ##1 (out_q != $past(out_q)))
        else $error("subframe does not open with a transition");
    AST_VAL_OVERRIDE: assert property ((s_load and val_q[BIT_VAL_OVR]) |=>
        word_q[28] == (($past(sf_q)) ? $past(val_q[BIT_VAL_SF1]) : $past(val_q[BIT_VAL_SF0])))
        else $error("validity override not applied");
    AST_VAL_DEFAULT: assert property ((s_load and (!val_q[BIT_VAL_OVR] && !from_rx)) |=>
        !word_q[28])
        else $error("validity not zero for audio interface source");
    AST_USER_ZERO: assert property ((s_load and !rx_status) |=> !word_q[29])
        else $error("user bit set without receiver status path");
    AST_EVEN_PARITY: assert property ($past(load) |-> ^word_q == 1'b0)
        else $error("subframe parity odd");
    AST_BLOCK_WRAP: assert property (frame_end && sf_q && frame_q == FRAME_LAST |=>
        frame_q == 8'h00)
        else $error("status block not 192 frames");
    AST_CS_BEYOND: assert property ((s_load and (!rx_status && frame_q >= CS_DEFINED))
        |=> !word_q[30])
        else $error("status bit past 40 not zero");
    AST_STRAP_SRC: assert property (cap_done_q |=> $stable({hw_q, strap_src_q}))
        else $error("strap latch moved after reset");
    AST_HW_AUTO: assert property (cap_done_q && hw_q |-> ##[1:2] (rx_en_q && pll_auto_q))
        else $error("hardware mode did not enable receiver");
endmodule : sptx_top

// >>> testbench/sptx_line_rx.sv
`timescale 1ns/100ps
module sptx_line_rx #(
    parameter int unsigned H = 2
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        line_in,
    output logic [15:0]      edges_out,
    output logic             bad_out
);
    logic        last_q;
    logic [15:0] gap_q;
    wire         flip = line_in != last_q;
    // biphase marks move on whole half cells only, a preamble waits three at most
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_q    <= 1'b0;
            gap_q     <= 16'h0000;
            edges_out <= 16'h0000;
            bad_out   <= 1'b0;
        end else begin
            last_q <= line_in;
            gap_q  <= flip ? 16'h0001 : gap_q + 16'h0001;
            if (flip) edges_out <= edges_out + 16'h0001;
            if (flip && edges_out != 0 && (gap_q % H != 0 || gap_q > 3 * H)) bad_out <= 1'b1;
        end
    end
endmodule : sptx_line_rx

// >>> testbench/sptx_top_tb.sv
`timescale 1ns/100ps
module sptx_top_tb;
    import sptx_pkg::*;
    logic        clk, rst_n, awv, wv, bre, arv, rre, av, rxv, rb, hw;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdv;
    logic [23:0] smp;
    logic [1:0]  rsp;
    wire         awr, wrd, bv, arr, rvl, ardy, rxr, txo, bad, rxen, pauto, msel;
    wire  [1:0]  br, rr, band;
    wire  [31:0] rdat;
    wire  [15:0] edges;
    int          n_errors, compares, n;
    sptx_top #(.HALF_CELL_CYCLES(16'h0002)) u_dut (
        .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
        .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf),
        .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br),
        .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bre), .S_AXI_ARADDR_IN(ara),
        .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat),
        .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rvl), .S_AXI_RREADY_IN(rre),
        .RX_VALID_IN(rxv), .RX_SAMPLE_IN(smp), .RX_VALIDITY_IN(rb), .RX_USER_IN(rb),
        .RX_STATUS_IN(rb), .RX_READY_OUT(rxr), .AIF_VALID_IN(av), .AIF_SAMPLE_IN(smp),
        .AIF_READY_OUT(ardy), .HW_MODE_IN(hw), .STRAP_PIN_TX_SOURCE_IN(hw),
        .STRAP_BCLK_IN(hw), .RX_FREQ_BAND_IN({hw, 1'b0}), .RX_ENABLE_OUT(rxen),
        .PLL_AUTO_OUT(pauto), .PLL_FREQ_BAND_OUT(band), .AUDIO_IF_MASTER_SEL_OUT(msel),
        .TX_OUT_PIN_OUT(txo));
    sptx_line_rx #(.H(2)) u_rx (.clk_in(clk), .rst_n_in(rst_n), .line_in(txo),
        .edges_out(edges), .bad_out(bad));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        forever begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) begin
                bre <= 1'b0;
                rsp = br;
                break;
            end
        end
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        forever begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rvl) begin
                rre <= 1'b0;
                rdv = rdat;
                rsp = rr;
                break;
            end
        end
    endtask : rd
    task automatic print_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic t_regs;
        rd(12'h018); chk(rdv, 32'h0000_0000);
        rd(12'h054); chk(rdv, 32'h0000_0071);
        rd(12'h078); chk(rdv, 32'h0000_0004);
        rd(12'h3fc); chk(32'(rsp), 32'(RESP_SLVERR));
        wr(12'h3fc, 32'h0000_00ff); chk(32'(rsp), 32'(RESP_SLVERR));
        wr(12'h018, 32'h0000_00e0); rd(12'h018); chk(rdv, 32'h0000_00e0);
        wr(12'h018, 32'h0000_0000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_fill;
        n = 0;
        av <= 1'b1;
        repeat (24) begin
            @(posedge clk);
            if (ardy) n++;
            if (ardy) smp <= smp + 24'h00_0001;
        end
        av <= 1'b0;
        chk(32'(n), 32'(FIFO_DEPTH)); chk(32'(edges), 32'h0000_0000);
        $display("test fill done");
    endtask : t_fill
    task automatic t_power;
        // line only moves once the power bit is cleared
        wr(12'h078, 32'h0000_0000);
        repeat (1200) @(posedge clk);
        chk(32'(edges != 0), 32'h0000_0001); chk(32'(bad), 32'h0000_0000);
        chk(32'(ardy), 32'h0000_0001);
        $display("test power done");
    endtask : t_power
    task automatic t_src;
        int k;
        k = 0;
        wr(12'h054, 32'h0000_0031);
        wr(12'h018, 32'h0000_00e0);
        rxv <= 1'b1;
        n = 0;
        // ready pulses once per subframe when full, so count it over the window
        repeat (600) begin
            @(posedge clk);
            if (rxr) n++;
            if (ardy) k++;
        end
        chk(32'(k), 32'h0000_0000); chk(32'(n != 0), 32'h0000_0001);
        chk(32'(bad), 32'h0000_0000);
        $display("test source done");
    endtask : t_src
    task automatic t_block;
        // receiver data with register status, run past one full status block
        wr(12'h054, 32'h0000_00b1);
        repeat (49500) @(posedge clk);
        rd(12'h08c);
        chk(32'(rdv[15:8] < 8'h20), 32'h0000_0001);
        chk(32'({rdv[4], rdv[0]}), 32'h0000_0001);
        chk(32'(bad), 32'h0000_0000);
        $display("test block done");
    endtask : t_block
    task automatic t_hw;
        rst_n <= 1'b0;
        hw    <= 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'({rxen, pauto, msel, band}), 32'h0000_001e);
        chk(32'(txo), 32'h0000_0000);
        rd(12'h08c);
        chk(32'(rdv[3:0]), 32'h0000_000e);
        wr(12'h054, 32'h0000_0031);
        repeat (2) @(posedge clk);
        chk(32'({ardy, rxr}), 32'h0000_0002);
        $display("test hw done");
    endtask : t_hw
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rst_n = 0; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; av = 0; rxv = 0;
        rb = 1; hw = 0; awa = 0; ara = 0; wd = 0; smp = 24'h00_0001;
        n_errors = 0; compares = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs(); t_fill(); t_power(); t_src(); t_block(); t_hw();
        print_verdict();
    end
    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule : sptx_top_tb
